// [src/tsh_timeslot_handler.sv]
// Purpose: Serial frame interface and timeslot handler with four controller data access registers.
// Assumes: 40 MHz clk, synchronous active-high reset, APB register access.
// Notes: Pins are split into in, out and output enable.
// Summary of operation
// - Each rising frame sync edge starts a new frame; slots count from it.
// - Double-rate clock runs at twice the bit rate, bit clock at the bit rate.
// - Bits launch on first double-rate rise, sample on second double-rate fall.
// - An interface control bit enables or disables the whole serial interface.
// - Active transceiver: device makes frame sync and clocks, locked to line frame.
// - Transceiver disabled: clock and frame sync pins become inputs, data keeps running.
// - Transceiver disabled: clock mode bit picks double-rate or single-rate input.
// - Internal mode gives 8 kHz sync, 1536 kHz clock, 768 kHz bit clock.
// - Channel 0 carries bearer, signalling, monitor and command/indicate data.
// - Channel 1 carries intercom, monitor, command/indicate; channel 2 bus access bits.
// - Each unit picks one of the slots; output line chosen, input opposite.
// - Reset assignments follow the standard terminal master frame.
// - Internal clock gives 12 slots; external clock allows up to 32.
// - Each access register has its own slot 0..31 and port register.
// - Access register output always uses its own slot and port.
// - Exchange bit set makes each pair member take input by its partner's setting.
// - Input and output enables gate each register; disabled input retains value.
// - Exchange bit crosses the input enables; output enables stay fixed.
// - Loops, shifts, monitors and gives controller access to any slot.
`include "tsh_defs.svh"

module tsh_timeslot_handler
    import tsh_pkg::*;
#(
    parameter int UNITS = 6
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lineFrameMark,
    input wire logic frameSyncIn,
    output logic frameSyncOut,
    output logic frameSyncOe,
    input wire logic doubleRateClockIn,
    output logic doubleRateClockOut,
    output logic doubleRateClockOe,
    output logic bitClockOut,
    input wire logic upstreamDataIn,
    output logic upstreamDataOut,
    output logic upstreamDataOe,
    input wire logic downstreamDataIn,
    output logic downstreamDataOut,
    output logic downstreamDataOe,
    input wire logic [1:0][7:0] trTxByte,
    output logic [1:0][7:0] trRxByte,
    output logic [1:0] trRxStrobe
);

    // ======================================================================
    // Derived timing.
    localparam logic [`TSH_NCO_BITS-1:0] NCO_INC =
        `TSH_NCO_BITS'((64'(2 * `TSH_DCL_KHZ) << `TSH_NCO_BITS) / `TSH_CLK_KHZ);
    localparam logic [7:0] INT_LAST_BIT = 8'((`TSH_BIT_KBPS * 1000) / `TSH_FRAME_HZ - 1);

    // ======================================================================
    // Registers.
    logic ifDisable_reg, clkMode_reg, trDisable_reg;
    tsh_pair_ctrl_s pairCtrl_reg [2];
    tsh_slot_port_s slotPort_reg [UNITS];
    logic [7:0] cdaData_reg [4];
    logic [7:0] bitCount_reg, bitCount_next;
    logic [1:0] phase_reg;
    logic [`TSH_NCO_BITS-1:0] nco_reg;
    logic frameValid_reg, restartPend_reg;
    logic [2:0] fsSync_reg, dclSync_reg, duSync_reg, ddSync_reg;
    logic fsFilt_reg, dclFilt_reg, duFilt_reg, ddFilt_reg;
    logic [6:0] duShift_reg, ddShift_reg;

    wire logic internalClk = !trDisable_reg;
    wire logic running = !ifDisable_reg;
    wire logic apbWrite = psel && penable && pready && pwrite;

    // ======================================================================
    // Pin synchronisers: a change counts once stages two and three agree.
    always_ff @(posedge clk) begin
        if (reset) begin
            fsSync_reg <= 3'h0;
            dclSync_reg <= 3'h0;
            duSync_reg <= 3'h0;
            ddSync_reg <= 3'h0;
            fsFilt_reg <= 1'b0;
            dclFilt_reg <= 1'b0;
            duFilt_reg <= 1'b0;
            ddFilt_reg <= 1'b0;
        end else begin
            fsSync_reg <= {fsSync_reg[1:0], frameSyncIn};
            dclSync_reg <= {dclSync_reg[1:0], doubleRateClockIn};
            duSync_reg <= {duSync_reg[1:0], upstreamDataIn};
            ddSync_reg <= {ddSync_reg[1:0], downstreamDataIn};
            if (fsSync_reg[1] == fsSync_reg[2]) fsFilt_reg <= fsSync_reg[2];
            if (dclSync_reg[1] == dclSync_reg[2]) dclFilt_reg <= dclSync_reg[2];
            if (duSync_reg[1] == duSync_reg[2]) duFilt_reg <= duSync_reg[2];
            if (ddSync_reg[1] == ddSync_reg[2]) ddFilt_reg <= ddSync_reg[2];
        end
    end

    wire logic extFsRise = (fsSync_reg[1] == fsSync_reg[2]) && fsSync_reg[2] && !fsFilt_reg;
    wire logic extDclRise = (dclSync_reg[1] == dclSync_reg[2]) && dclSync_reg[2] && !dclFilt_reg;
    wire logic extDclFall = (dclSync_reg[1] == dclSync_reg[2]) && !dclSync_reg[2] && dclFilt_reg;
    wire logic ncoTick = ({1'b0, nco_reg} + {1'b0, NCO_INC}) > {1'b0, {`TSH_NCO_BITS{1'b1}}};

    // ======================================================================
    // Bit timing events.
    logic edgeRise, edgeFall, launchEvt, sampleEvt, restartReq, singleMode;
    always_comb begin
        singleMode = !internalClk && clkMode_reg;
        edgeRise = internalClk ? (ncoTick && !phase_reg[0]) : extDclRise;
        edgeFall = internalClk ? (ncoTick && phase_reg[0]) : extDclFall;
        restartReq = internalClk ? lineFrameMark : extFsRise;
        if (singleMode) begin
            launchEvt = running && edgeRise;
            sampleEvt = running && edgeFall;
        end else begin
            launchEvt = running && edgeRise && (phase_reg == 2'h0 || (!internalClk && extFsRise));
            sampleEvt = running && edgeFall && phase_reg == 2'h3;
        end
    end

    // Internal clock generator and bit phase tracking.
    always_ff @(posedge clk) begin
        if (reset || !running) begin
            nco_reg <= '0;
            phase_reg <= 2'h0;
            doubleRateClockOut <= 1'b0;
            bitClockOut <= 1'b0;
        end else begin
            nco_reg <= internalClk ? nco_reg + NCO_INC : '0;
            if (!internalClk && extFsRise) begin
                phase_reg <= edgeRise ? 2'h1 : 2'h0;
            end else if (edgeRise || (edgeFall && phase_reg[0])) begin
                phase_reg <= phase_reg + 2'h1;
            end
            if (internalClk && ncoTick) begin
                doubleRateClockOut <= ~phase_reg[0];
                bitClockOut <= ~phase_reg[1];
            end else if (!internalClk && singleMode) begin
                bitClockOut <= dclFilt_reg;
            end else if (!internalClk && edgeRise) begin
                bitClockOut <= launchEvt;
            end
        end
    end

    // ======================================================================
    // Frame bit counter; internal frame holds 96 bits, external up to 256.
    always_comb begin
        if (restartPend_reg || restartReq) begin
            bitCount_next = 8'h00;
        end else if (internalClk && bitCount_reg == INT_LAST_BIT) begin
            bitCount_next = 8'h00;
        end else begin
            bitCount_next = bitCount_reg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !running) begin
            bitCount_reg <= 8'hFF;
            restartPend_reg <= 1'b0;
            frameValid_reg <= 1'b0;
            frameSyncOut <= 1'b0;
        end else begin
            if (launchEvt) begin
                bitCount_reg <= bitCount_next;
                restartPend_reg <= 1'b0;
                if (bitCount_next == 8'h00) frameValid_reg <= 1'b1;
                frameSyncOut <= internalClk && bitCount_next == 8'h00;
            end else if (restartReq) begin
                restartPend_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            frameSyncOe <= 1'b0;
            doubleRateClockOe <= 1'b0;
        end else begin
            frameSyncOe <= running && internalClk;
            doubleRateClockOe <= running && internalClk;
        end
    end

    // ======================================================================
    // Per-unit routing: units 0..3 are access registers, 4..5 transceiver bearers.
    logic [UNITS-1:0] outEnU, inEnU, outPortU;
    logic [UNITS-1:0] inPortU;
    logic [4:0] inSlotU [UNITS];
    logic [7:0] txByteU [UNITS];
    genvar gu;
    generate
        for (gu = 0; gu < UNITS; gu++) begin : g_unit
            if (gu < 4) begin : g_cda
                localparam int P = gu / 2;
                localparam int Y = gu % 2;
                wire logic swap = pairCtrl_reg[P].swap;
                assign outEnU[gu] = pairCtrl_reg[P].outEn[Y];
                assign inEnU[gu] = swap ? pairCtrl_reg[P].inEn[1-Y] : pairCtrl_reg[P].inEn[Y];
                assign inSlotU[gu] = swap ? slotPort_reg[gu ^ 1].slot : slotPort_reg[gu].slot;
                assign inPortU[gu] = swap ? slotPort_reg[gu ^ 1].portSel : slotPort_reg[gu].portSel;
                assign txByteU[gu] = cdaData_reg[gu];
            end else begin : g_tr
                assign outEnU[gu] = 1'b1;
                assign inEnU[gu] = 1'b1;
                assign inSlotU[gu] = slotPort_reg[gu].slot;
                assign inPortU[gu] = slotPort_reg[gu].portSel;
                assign txByteU[gu] = trTxByte[gu-4];
            end
            assign outPortU[gu] = slotPort_reg[gu].portSel;
        end
    endgenerate

    // Output on downstream when port select is 0, input then from upstream.
    logic duDrive, ddDrive, duBit, ddBit;
    always_comb begin
        duDrive = 1'b0;
        ddDrive = 1'b0;
        duBit = 1'b0;
        ddBit = 1'b0;
        for (int u = 0; u < UNITS; u++) begin
            if (outEnU[u] && slotPort_reg[u].slot == bitCount_next[7:3]) begin
                if (outPortU[u]) begin
                    duDrive = 1'b1;
                    duBit = duBit | txByteU[u][3'h7 - bitCount_next[2:0]];
                end else begin
                    ddDrive = 1'b1;
                    ddBit = ddBit | txByteU[u][3'h7 - bitCount_next[2:0]];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !running) begin
            upstreamDataOut <= 1'b0;
            upstreamDataOe <= 1'b0;
            downstreamDataOut <= 1'b0;
            downstreamDataOe <= 1'b0;
        end else if (launchEvt) begin
            upstreamDataOut <= duBit;
            upstreamDataOe <= duDrive;
            downstreamDataOut <= ddBit;
            downstreamDataOe <= ddDrive;
        end
    end

    // ======================================================================
    // Input capture: bytes complete at the sample of bit seven of a slot.
    wire logic byteDone = sampleEvt && frameValid_reg && bitCount_reg[2:0] == 3'h7;
    wire logic duNow = (duSync_reg[1] == duSync_reg[2]) ? duSync_reg[2] : duFilt_reg;
    wire logic ddNow = (ddSync_reg[1] == ddSync_reg[2]) ? ddSync_reg[2] : ddFilt_reg;
    wire logic [7:0] duByte = {duShift_reg, duNow};
    wire logic [7:0] ddByte = {ddShift_reg, ddNow};
    logic [UNITS-1:0] loadU;
    always_comb begin
        for (int u = 0; u < UNITS; u++) begin
            loadU[u] = byteDone && inEnU[u] && inSlotU[u] == bitCount_reg[7:3];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            duShift_reg <= 7'h00;
            ddShift_reg <= 7'h00;
        end else if (sampleEvt) begin
            duShift_reg <= {duShift_reg[5:0], duNow};
            ddShift_reg <= {ddShift_reg[5:0], ddNow};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trRxByte <= '0;
            trRxStrobe <= 2'h0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                trRxStrobe[t] <= loadU[t+4];
                if (loadU[t+4]) trRxByte[t] <= inPortU[t+4] ? ddByte : duByte;
            end
        end
    end

    // Hardware capture wins over a software write in the same cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) cdaData_reg[i] <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (loadU[i]) begin
                    cdaData_reg[i] <= inPortU[i] ? ddByte : duByte;
                end else if (apbWrite && paddr == `TSH_OFF_DATA0 + 8'(4 * i)) begin
                    cdaData_reg[i] <= pwdata[7:0];
                end
            end
        end
    end

    // ======================================================================
    // APB register file.
    always_ff @(posedge clk) begin
        if (reset) begin
            ifDisable_reg <= 1'b0;
            clkMode_reg <= 1'b0;
            trDisable_reg <= 1'b0;
            pairCtrl_reg[0] <= `TSH_RST_PAIR;
            pairCtrl_reg[1] <= `TSH_RST_PAIR;
            slotPort_reg[0] <= `TSH_RST_CDA_SLOT0;
            slotPort_reg[1] <= `TSH_RST_CDA_SLOT1;
            slotPort_reg[2] <= `TSH_RST_CDA_SLOT2;
            slotPort_reg[3] <= `TSH_RST_CDA_SLOT3;
            slotPort_reg[4] <= `TSH_RST_TR_SLOT0;
            slotPort_reg[5] <= `TSH_RST_TR_SLOT1;
        end else if (apbWrite) begin
            if (paddr == `TSH_OFF_IF_CTRL) begin
                ifDisable_reg <= pwdata[`TSH_BIT_IF_DISABLE];
                clkMode_reg <= pwdata[`TSH_BIT_CLK_MODE];
            end
            if (paddr == `TSH_OFF_TR_CTRL) trDisable_reg <= pwdata[`TSH_BIT_TR_DISABLE];
            if (paddr == `TSH_OFF_PAIR1) pairCtrl_reg[0] <= pwdata[4:0];
            if (paddr == `TSH_OFF_PAIR2) pairCtrl_reg[1] <= pwdata[4:0];
            for (int i = 0; i < UNITS; i++) begin
                if (paddr == (i < 4 ? `TSH_OFF_SLOT0 : `TSH_OFF_TRSLOT0 - 8'h10) + 8'(4 * i)) begin
                    slotPort_reg[i] <= {pwdata[`TSH_BIT_PORT_SEL], 2'b00, pwdata[4:0]};
                end
            end
        end
    end

    logic [31:0] readValue;
    logic readHit;
    always_comb begin
        readValue = 32'h0000_0000;
        readHit = 1'b1;
        case (paddr)
            `TSH_OFF_IF_CTRL: readValue = {30'h0, clkMode_reg, ifDisable_reg};
            `TSH_OFF_TR_CTRL: readValue = {31'h0, trDisable_reg};
            `TSH_OFF_PAIR1: readValue = {27'h0, pairCtrl_reg[0]};
            `TSH_OFF_PAIR2: readValue = {27'h0, pairCtrl_reg[1]};
            `TSH_OFF_STATUS: readValue = {19'h0, bitCount_reg[7:3], 7'h0, frameValid_reg};
            default: begin
                readHit = 1'b0;
                for (int i = 0; i < UNITS; i++) begin
                    if (i < 4 && paddr == `TSH_OFF_DATA0 + 8'(4 * i)) begin
                        readValue = {24'h0, cdaData_reg[i]};
                        readHit = 1'b1;
                    end
                    if (paddr == (i < 4 ? `TSH_OFF_SLOT0 : `TSH_OFF_TRSLOT0 - 8'h10) + 8'(4 * i)) begin
                        readValue = {24'h0, slotPort_reg[i]};
                        readHit = 1'b1;
                    end
                end
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? readValue : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !readHit;
        end
    end

    // ======================================================================
    // Checks.
    a_frame_restart: assert property (@(posedge clk) disable iff (reset)
        (launchEvt && (restartPend_reg || restartReq)) |=> bitCount_reg == 8'h00)
        else $error("Frame did not restart at frame sync.");
    a_bit_clock_phase: assert property (@(posedge clk) disable iff (reset)
        (internalClk && running && ncoTick && phase_reg == 2'h0) |=> bitClockOut && doubleRateClockOut)
        else $error("Bit clock not high at launch edge.");
    a_sample_point: assert property (@(posedge clk) disable iff (reset)
        (internalClk && sampleEvt) |=> !doubleRateClockOut && !bitClockOut)
        else $error("Sample not on second falling clock edge.");
    a_interface_off: assert property (@(posedge clk) disable iff (reset)
        ifDisable_reg |=> !upstreamDataOe && !downstreamDataOe && !frameSyncOe && !doubleRateClockOe)
        else $error("Pins driven while interface disabled.");
    a_internal_drive: assert property (@(posedge clk) disable iff (reset)
        (running && internalClk) |=> frameSyncOe && doubleRateClockOe)
        else $error("Clocks not driven with transceiver active.");
    a_external_pins: assert property (@(posedge clk) disable iff (reset)
        trDisable_reg |=> !frameSyncOe && !doubleRateClockOe)
        else $error("Clock pins driven with transceiver disabled.");
    a_single_mode: assert property (@(posedge clk) disable iff (reset)
        (running && singleMode && extDclRise) |-> launchEvt)
        else $error("Single-rate rise did not launch a bit.");
    a_frame_length: assert property (@(posedge clk) disable iff (reset)
        (internalClk && launchEvt && bitCount_reg == 8'd95) |=> bitCount_reg == 8'h00)
        else $error("Internal frame is not 96 bits long.");
    a_swap_input: assert property (@(posedge clk) disable iff (reset)
        (loadU[1] && pairCtrl_reg[0].swap) |-> slotPort_reg[0].slot == bitCount_reg[7:3])
        else $error("Swapped input did not use the partner slot.");
    a_hold_disabled: assert property (@(posedge clk) disable iff (reset)
        (!inEnU[2] && !(apbWrite && paddr == 8'h18)) |=> $stable(cdaData_reg[2]))
        else $error("Disabled access register changed.");

endmodule : tsh_timeslot_handler

// [src/tsh_defs.svh]
// Purpose: Offsets, field positions, reset values and timing figures of the timeslot handler.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Included by the handler module only.
`ifndef TSH_DEFS_SVH
`define TSH_DEFS_SVH

// ==========================================================================
// Register offsets
`define TSH_OFF_IF_CTRL 8'h00
`define TSH_OFF_TR_CTRL 8'h04
`define TSH_OFF_PAIR1 8'h08
`define TSH_OFF_PAIR2 8'h0C
`define TSH_OFF_DATA0 8'h10
`define TSH_OFF_SLOT0 8'h20
`define TSH_OFF_TRSLOT0 8'h30
`define TSH_OFF_STATUS 8'h38

// ==========================================================================
// Field positions
`define TSH_BIT_IF_DISABLE 0
`define TSH_BIT_CLK_MODE 1
`define TSH_BIT_TR_DISABLE 0
`define TSH_BIT_PORT_SEL 7

// ==========================================================================
// Reset values
`define TSH_RST_PAIR 5'h0_0
`define TSH_RST_CDA_SLOT0 8'h0_2
`define TSH_RST_CDA_SLOT1 8'h0_3
`define TSH_RST_CDA_SLOT2 8'h0_4
`define TSH_RST_CDA_SLOT3 8'h0_5
`define TSH_RST_TR_SLOT0 8'h0_0
`define TSH_RST_TR_SLOT1 8'h0_1

// ==========================================================================
// Timing figures
`define TSH_CLK_KHZ 40000
`define TSH_DCL_KHZ 1536
`define TSH_BIT_KBPS 768
`define TSH_FRAME_HZ 8000
`define TSH_NCO_BITS 16

`endif

// [src/tsh_pkg.sv]
// Purpose: Types shared by the timeslot handler.
// Assumes: Nothing beyond the register layout.
// Notes: Struct layouts match the register bit positions.
package tsh_pkg;

    // ======================================================================
    // Slot and port selection of one functional unit.
    typedef struct packed {
        logic portSel;
        logic [1:0] unused;
        logic [4:0] slot;
    } tsh_slot_port_s;

    // ======================================================================
    // Control of one pair of access data registers.
    typedef struct packed {
        logic swap;
        logic [1:0] outEn;
        logic [1:0] inEn;
    } tsh_pair_ctrl_s;

endpackage : tsh_pkg

// [tb/tsh_far_device.sv]
// Purpose: Far-side serial device that sends one fixed byte per upstream slot.
// Assumes: Bit clock comes from the handler, frame sync from the handler or the bench's fsIn; clk only samples them.
// Notes: Slot n carries the byte C3 plus n.
module tsh_far_device (
    input wire logic clk,
    input wire logic bitClock,
    input wire logic frameSync,
    output logic upstreamData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bitClockPrev;
    logic [7:0] slotByte;
    int bitNo;
    initial begin
        bitClockPrev = 1'b0;
        bitNo = 0;
        slotByte = 8'h00;
        upstreamData = 1'b1;
    end
    // ======================================================================
    // Launch
    always @(posedge clk) begin
        bitClockPrev <= bitClock;
        if (bitClock && !bitClockPrev) begin
            bitNo = frameSync ? 0 : bitNo + 1;
            slotByte = 8'hC3 + 8'(bitNo / 8);
            upstreamData <= slotByte[7 - (bitNo % 8)];
        end
    end
endmodule : tsh_far_device

// [tb/tsh_timeslot_handler_tb.sv]
// Purpose: Self-checking bench for the timeslot handler.
// Assumes: 40 MHz clk, APB master, far device on upstream data, pull-up on downstream.
// Notes: Expected read results wait in a queue until the read answer appears.
module tsh_timeslot_handler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, fsIn, dclIn, farUp;
    logic fsOut, fsOe, dclOut, dclOe, bclOut, upOut, upOe, dnOut, dnOe;
    logic lineMark, checkTr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lfsrState;
    logic [1:0][7:0] trTx, trRx;
    logic [1:0] trRxStrobe;
    logic [32:0] expQ[$];
    logic [32:0] expNow;
    int fails, samples_checked, dclCount;
    wire upWire = upOe ? upOut : farUp;
    wire dnWire = dnOe ? dnOut : 1'b1;
    wire fsWire = fsOe ? fsOut : fsIn;
    tsh_timeslot_handler dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lineFrameMark(lineMark), .frameSyncIn(fsIn), .frameSyncOut(fsOut),
        .frameSyncOe(fsOe), .doubleRateClockIn(dclIn), .doubleRateClockOut(dclOut),
        .doubleRateClockOe(dclOe), .bitClockOut(bclOut), .upstreamDataIn(upWire),
        .upstreamDataOut(upOut), .upstreamDataOe(upOe), .downstreamDataIn(dnWire),
        .downstreamDataOut(dnOut), .downstreamDataOe(dnOe), .trTxByte(trTx),
        .trRxByte(trRx), .trRxStrobe(trRxStrobe));
    tsh_far_device far (.clk(clk), .bitClock(bclOut), .frameSync(fsWire), .upstreamData(farUp));
    // ======================================================================
    // Clocks and external frame sync
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        dclIn = 1'b0;
        #37;
        forever #100 dclIn = ~dclIn;
    end
    always @(posedge dclIn) begin
        dclCount <= (dclCount == 624) ? 0 : dclCount + 1;
        fsIn <= (dclCount == 0);
    end
    // ======================================================================
    // Tasks
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb_xfer
    task automatic read_expect(input logic [7:0] a, input logic [31:0] d, input logic e);
        expQ.push_back({e, d});
        apb_xfer(1'b0, a, 32'h0000_0000);
    endtask : read_expect
    task automatic report_and_stop;
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // ======================================================================
    // Read monitor
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            expNow = (expQ.size() > 0) ? expQ.pop_front() : 33'h1_FFFF_FFFF;
            samples_checked++;
            if ({pslverr, prdata} !== expNow) begin
                fails++;
                $display("BAD %0t exp %h got %h", $time, expNow, {pslverr, prdata});
            end
        end
    end
    // Transceiver units take slots 0 and 1 from upstream, sent by the far device.
    always @(posedge clk) begin
        for (int t = 0; t < 2; t++) begin
            if (checkTr && trRxStrobe[t] === 1'b1) begin
                samples_checked++;
                if (trRx[t] !== 8'hC3 + 8'(t)) begin
                    fails++;
                    $display("BAD %0t exp %h got %h", $time, 8'hC3 + 8'(t), trRx[t]);
                end
            end
        end
    end
    initial begin
        #(25 * 80000);
        fails++;
        report_and_stop;
    end
    // ======================================================================
    // Scenarios
    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; fsIn = 1'b0; dclCount = 0; fails = 0; samples_checked = 0;
        lfsrState = 32'h0001_79B8; trTx = 16'h0000;
        checkTr = 1'b0;
        lineMark = 1'b0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        trTx <= lfsrState[15:0];
        @(posedge clk);
        for (int i = 0; i < 4; i++) read_expect(8'h20 + 8'(4 * i), 32'(i + 2), 1'b0);
        read_expect(8'h34, 32'h0000_0001, 1'b0);
        read_expect(8'h3C, 32'h0000_0000, 1'b1);
        apb_xfer(1'b1, 8'h08, 32'h0000_0001);
        checkTr <= 1'b1;
        repeat (10000) @(posedge clk);
        checkTr <= 1'b0;
        apb_xfer(1'b1, 8'h08, 32'h0000_0000);
        apb_xfer(1'b1, 8'h20, 32'h0000_0003);
        repeat (5000) @(posedge clk);
        read_expect(8'h10, 32'h0000_00C5, 1'b0);
        apb_xfer(1'b1, 8'h08, 32'h0000_0011);
        repeat (10000) @(posedge clk);
        apb_xfer(1'b1, 8'h08, 32'h0000_0010);
        read_expect(8'h14, 32'h0000_00C6, 1'b0);
        read_expect(8'h10, 32'h0000_00C5, 1'b0);
        apb_xfer(1'b1, 8'h28, 32'h0000_0006);
        apb_xfer(1'b1, 8'h2C, 32'h0000_0086);
        for (int m = 0; m < 3; m++) begin
            lfsrState = lfsr_next(lfsrState);
            apb_xfer(1'b1, 8'h04, 32'(m != 0));
            apb_xfer(1'b1, 8'h00, 32'(m == 2) << 1);
            apb_xfer(1'b1, 8'h18, {24'h00_0000, lfsrState[7:0]});
            apb_xfer(1'b1, 8'h0C, 32'h0000_0006);
            if (m == 0) begin
                lineMark <= 1'b1;
                @(posedge clk);
                lineMark <= 1'b0;
            end
            repeat (12000) @(posedge clk);
            apb_xfer(1'b1, 8'h0C, 32'h0000_0000);
            read_expect(8'h1C, {24'h00_0000, lfsrState[7:0]}, 1'b0);
        end
        report_and_stop;
    end
endmodule : tsh_timeslot_handler_tb
